// ---- design/ccw_cfg.svh ----
// offsets, field positions, opcodes, reset values and counts of the clear/complement core
`ifndef CCW_CFG_SVH
`define CCW_CFG_SVH
// register byte offsets
`define CCW_OFF_CTRL    8'h00
`define CCW_OFF_INSTR   8'h04
`define CCW_OFF_WREG    8'h08
`define CCW_OFF_STATUS  8'h0C
`define CCW_OFF_BANK    8'h10
`define CCW_OFF_INDEX   8'h14
`define CCW_OFF_MADDR   8'h18
`define CCW_OFF_MDATA   8'h1C
`define CCW_OFF_WDOG    8'h20
// control and status field positions
`define CCW_CTRL_EXT    0
`define CCW_CTRL_WDEN   1
`define CCW_ST_Z        0
`define CCW_ST_N        1
`define CCW_ST_PWDN     2
`define CCW_ST_TO       3
`define CCW_ST_BUSY     8
// reset values
`define CCW_RST_CTRL    2'h0
`define CCW_RST_FLAG_HI 1'b1
// opcode patterns and operand fields
`define CCW_OPC_CLR     7'h35
`define CCW_OPC_INV     6'h07
`define CCW_OPC_WDOG    16'h0004
`define CCW_FLD_A       8
`define CCW_FLD_D       9
// addressing constants
`define CCW_IDX_LIMIT   8'h5F
`define CCW_ACC_SPLIT   8'h80
`define CCW_ACC_HIGH    4'hF
`define CCW_MEM_WORDS   4096
// watchdog defaults in clock cycles and postscaler steps
`define CCW_WDOG_PERIOD 1024
`define CCW_WDOG_POST   128
`endif

// ---- design/ccw_pkg.sv ----
// types shared by the clear/complement/watchdog core
package ccw_pkg;
   // four phases of one instruction cycle plus idle
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_Q1,
      PH_Q2,
      PH_Q3,
      PH_Q4
   } ccw_phase_e;
   // decoded instruction kind
   typedef enum logic [1:0] {
      OP_NONE,
      OP_CLR,
      OP_INV,
      OP_WDOG
   } ccw_op_e;
endpackage : ccw_pkg

// ---- design/ccw_qseq.sv ----
// four-phase instruction cycle sequencer
`timescale 1ns/1ps
module ccw_qseq (
   // clock and reset
   input  wire logic                mclk,
   input  wire logic                arst_n,
   // control
   input  wire logic                start,
   // phase state
   output ccw_pkg::ccw_phase_e      phase,
   output logic                     busy
);
   ccw_pkg::ccw_phase_e phase_ff; // current phase

   // ************************************
   // phase stepping
   // ************************************
   // one step per clock, idle until a start
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         phase_ff <= ccw_pkg::PH_IDLE;
      end else begin
         unique case (phase_ff)
            ccw_pkg::PH_IDLE: if (start) phase_ff <= ccw_pkg::PH_Q1;
            ccw_pkg::PH_Q1:   phase_ff <= ccw_pkg::PH_Q2;
            ccw_pkg::PH_Q2:   phase_ff <= ccw_pkg::PH_Q3;
            ccw_pkg::PH_Q3:   phase_ff <= ccw_pkg::PH_Q4;
            ccw_pkg::PH_Q4:   phase_ff <= ccw_pkg::PH_IDLE;
            default:          phase_ff <= ccw_pkg::PH_IDLE;
         endcase
      end
   end

   assign phase = phase_ff;
   assign busy  = (phase_ff != ccw_pkg::PH_IDLE);
endmodule : ccw_qseq

// ---- design/ccw_watchdog.sv ----
// watchdog counter with postscaler and restart
`timescale 1ns/1ps
`include "ccw_cfg.svh"
module ccw_watchdog #(
   parameter int unsigned PERIOD = `CCW_WDOG_PERIOD,
   parameter int unsigned POST   = `CCW_WDOG_POST
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        arst_n,
   // control
   input  wire logic        enable,
   input  wire logic        restart,
   // state
   output logic [15:0]      count,
   output logic [7:0]       post,
   output logic             timeout
);
   logic [15:0] count_ff;   // watchdog counter
   logic [7:0]  post_ff;    // postscaler
   logic        timeout_ff; // one-cycle timeout pulse
   logic        wrap;       // counter at its last step

   assign wrap = (count_ff == 16'(PERIOD - 1));

   // ************************************
   // counting and restart
   // ************************************
   // restart wins over counting, so no timeout in that cycle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         count_ff   <= 16'h0000;
         post_ff    <= 8'h00;
         timeout_ff <= 1'b0;
      end else if (restart) begin
         count_ff   <= 16'h0000;
         post_ff    <= 8'h00;
         timeout_ff <= 1'b0;
      end else if (enable) begin
         count_ff   <= wrap ? 16'h0000 : count_ff + 16'h0001;
         timeout_ff <= wrap && (post_ff == 8'(POST - 1));
         if (wrap) begin
            post_ff <= (post_ff == 8'(POST - 1)) ? 8'h00 : post_ff + 8'h01;
         end
      end else begin
         timeout_ff <= 1'b0;
      end
   end

   assign count   = count_ff;
   assign post    = post_ff;
   assign timeout = timeout_ff;

   // ************************************
   // checks
   // ************************************
   a_counter_restart: assert property (@(posedge mclk) disable iff (!arst_n)
      restart |=> (count_ff == 16'h0000) && !timeout_ff)
      else $error("watchdog counter not restarted");
   a_postscaler_restart: assert property (@(posedge mclk) disable iff (!arst_n)
      restart |=> (post_ff == 8'h00) ##1 !timeout_ff)
      else $error("watchdog postscaler not restarted");
endmodule : ccw_watchdog

// ---- design/ccw_core.sv ----
// instruction core for clear, complement and watchdog restart, with ahb-lite registers
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ccw_cfg.svh"
// Operation
// - clear writes zero, sets zero flag
// - clear uses indexed offset at f<=95
// - watchdog restart restarts the counter
// - watchdog restart also clears postscaler
// - watchdog restart sets timeout, power-down flags
// - complement result is inverse of register
// - d zero: result to working register
// - d one: result back to register
// - a zero: address from access bank
// - a one: bank register selects bank
// - complement uses indexed offset at f<=95
module ccw_core #(
   parameter int unsigned WDOG_PERIOD = `CCW_WDOG_PERIOD,
   parameter int unsigned WDOG_POST   = `CCW_WDOG_POST
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        arst_n,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // side outputs
   output logic             ext_set_en,
   output logic             wdog_timeout
);
   // ************************************
   // declarations
   // ************************************
   logic                dp_act_ff;   // data phase pending
   logic                dp_wr_ff;    // pending phase is a write
   logic [7:0]          dp_addr_ff;  // pending register offset
   logic                rd_done_ff;  // read wait cycle done
   logic [31:0]         hrdata_ff;   // read data
   logic [31:0]         rd_mux;      // selected register value
   logic                addr_take;   // address phase accepted
   logic                bus_we;      // write data phase active
   logic [1:0]          ctrl_ff;     // ext set enable, watchdog enable
   logic [15:0]         instr_ff;    // last accepted opcode
   logic [7:0]          w_ff;        // working register
   logic                z_ff;        // zero flag
   logic                n_ff;        // negative flag
   logic                to_ff;       // timeout flag
   logic                pwdn_ff;     // power-down flag
   logic [3:0]          bank_ff;     // bank select register
   logic [11:0]         index_ff;    // base for indexed offset mode
   logic [11:0]         maddr_ff;    // software window address
   ccw_pkg::ccw_op_e    op_ff;       // instruction in flight
   logic                dest_f_ff;   // destination is the file register
   logic [11:0]         ea_ff;       // effective file address
   logic [7:0]          operand_ff;  // value read in Q2
   logic [7:0]          result_ff;   // value built in Q3
   ccw_pkg::ccw_op_e    nxt_op;      // decoded opcode kind
   logic [11:0]         nxt_ea;      // decoded effective address
   logic                start;       // opcode accepted
   logic                busy;        // instruction in flight
   ccw_pkg::ccw_phase_e phase;       // current phase
   logic                core_we;     // file write in Q4
   logic                wdog_restart; // watchdog restart pulse
   logic                wdog_pulse;   // watchdog timeout pulse
   logic [15:0]         wdog_count;   // watchdog counter
   logic [7:0]          wdog_post;    // watchdog postscaler
   logic [7:0]          mem [0:`CCW_MEM_WORDS-1]; // file registers

   // ************************************
   // ahb-lite slave
   // ************************************
   assign addr_take = hsel && htrans[1] && hready;
   assign hreadyout = !(dp_act_ff && !dp_wr_ff && !rd_done_ff);
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_ff;
   assign bus_we    = dp_act_ff && dp_wr_ff;

   // address phase capture, held while a read waits
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         dp_act_ff  <= 1'b0;
         dp_wr_ff   <= 1'b0;
         dp_addr_ff <= 8'h00;
      end else if (hreadyout) begin
         dp_act_ff <= addr_take;
         if (addr_take) begin
            dp_wr_ff   <= hwrite;
            dp_addr_ff <= {haddr[7:2], 2'b00};
         end
      end
   end

   // reads take one wait cycle so data comes from a flip-flop
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_done_ff <= 1'b0;
         hrdata_ff  <= 32'h0000_0000;
      end else if (dp_act_ff && !dp_wr_ff && !rd_done_ff) begin
         rd_done_ff <= 1'b1;
         hrdata_ff  <= rd_mux;
      end else begin
         rd_done_ff <= 1'b0;
      end
   end

   // register read mux, unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (dp_addr_ff)
         `CCW_OFF_CTRL:   rd_mux[1:0]  = ctrl_ff;
         `CCW_OFF_INSTR:  rd_mux[15:0] = instr_ff;
         `CCW_OFF_WREG:   rd_mux[7:0]  = w_ff;
         `CCW_OFF_STATUS: begin
            rd_mux[`CCW_ST_Z]    = z_ff;
            rd_mux[`CCW_ST_N]    = n_ff;
            rd_mux[`CCW_ST_PWDN] = pwdn_ff;
            rd_mux[`CCW_ST_TO]   = to_ff;
            rd_mux[`CCW_ST_BUSY] = busy;
         end
         `CCW_OFF_BANK:   rd_mux[3:0]  = bank_ff;
         `CCW_OFF_INDEX:  rd_mux[11:0] = index_ff;
         `CCW_OFF_MADDR:  rd_mux[11:0] = maddr_ff;
         `CCW_OFF_MDATA:  rd_mux[7:0]  = mem[maddr_ff];
         `CCW_OFF_WDOG:   rd_mux[23:0] = {wdog_post, wdog_count};
         default:         rd_mux       = 32'h0000_0000;
      endcase
   end

   // ************************************
   // configuration registers
   // ************************************
   // written at any time; instructions latch their address at start
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_ff  <= `CCW_RST_CTRL;
         bank_ff  <= 4'h0;
         index_ff <= 12'h000;
         maddr_ff <= 12'h000;
      end else if (bus_we) begin
         if (dp_addr_ff == `CCW_OFF_CTRL)  ctrl_ff  <= hwdata[1:0];
         if (dp_addr_ff == `CCW_OFF_BANK)  bank_ff  <= hwdata[3:0];
         if (dp_addr_ff == `CCW_OFF_INDEX) index_ff <= hwdata[11:0];
         if (dp_addr_ff == `CCW_OFF_MADDR) maddr_ff <= hwdata[11:0];
      end
   end

   assign ext_set_en = ctrl_ff[`CCW_CTRL_EXT];

   // ************************************
   // decode and effective address
   // ************************************
   // a new opcode is taken only while no instruction is in flight
   assign start = bus_we && (dp_addr_ff == `CCW_OFF_INSTR) && !busy;

   // opcode kind from its fixed bits
   always_comb begin
      if (hwdata[15:9] == `CCW_OPC_CLR) begin
         nxt_op = ccw_pkg::OP_CLR;
      end else if (hwdata[15:10] == `CCW_OPC_INV) begin
         nxt_op = ccw_pkg::OP_INV;
      end else if (hwdata[15:0] == `CCW_OPC_WDOG) begin
         nxt_op = ccw_pkg::OP_WDOG;
      end else begin
         nxt_op = ccw_pkg::OP_NONE;
      end
   end

   // file address from bank register, indexed offset or access bank
   always_comb begin
      if (hwdata[`CCW_FLD_A]) begin
         nxt_ea = {bank_ff, hwdata[7:0]};
      end else if (ext_set_en && (hwdata[7:0] <= `CCW_IDX_LIMIT)) begin
         nxt_ea = index_ff + {4'h0, hwdata[7:0]};
      end else if (hwdata[7:0] < `CCW_ACC_SPLIT) begin
         nxt_ea = {4'h0, hwdata[7:0]};
      end else begin
         nxt_ea = {`CCW_ACC_HIGH, hwdata[7:0]};
      end
   end

   // instruction latch at start
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         instr_ff  <= 16'h0000;
         op_ff     <= ccw_pkg::OP_NONE;
         dest_f_ff <= 1'b0;
         ea_ff     <= 12'h000;
      end else if (start) begin
         instr_ff  <= hwdata[15:0];
         op_ff     <= nxt_op;
         dest_f_ff <= hwdata[`CCW_FLD_D];
         ea_ff     <= nxt_ea;
      end
   end

   // ************************************
   // instruction cycle
   // ************************************
   ccw_qseq u_qseq (
      .mclk   (mclk),
      .arst_n (arst_n),
      .start  (start),
      .phase  (phase),
      .busy   (busy)
   );

   // read in Q2, build the result in Q3
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         operand_ff <= 8'h00;
         result_ff  <= 8'h00;
      end else if (phase == ccw_pkg::PH_Q2) begin
         operand_ff <= mem[ea_ff];
      end else if (phase == ccw_pkg::PH_Q3) begin
         if (op_ff == ccw_pkg::OP_CLR) begin
            result_ff <= 8'h00;
         end else begin
            result_ff <= ~operand_ff;
         end
      end
   end

   // file write in Q4 for clear, and complement with d one
   assign core_we = (phase == ccw_pkg::PH_Q4) &&
                    ((op_ff == ccw_pkg::OP_CLR) ||
                     ((op_ff == ccw_pkg::OP_INV) && dest_f_ff));

   // file registers, core write first, software window when idle
   always_ff @(posedge mclk) begin
      if (core_we) begin
         mem[ea_ff] <= result_ff;
      end else if (bus_we && !busy && (dp_addr_ff == `CCW_OFF_MDATA)) begin
         mem[maddr_ff] <= hwdata[7:0];
      end
   end

   // working register: complement with d zero, or software when idle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         w_ff <= 8'h00;
      end else if ((phase == ccw_pkg::PH_Q4) && (op_ff == ccw_pkg::OP_INV) && !dest_f_ff) begin
         w_ff <= result_ff;
      end else if (bus_we && !busy && (dp_addr_ff == `CCW_OFF_WREG)) begin
         w_ff <= hwdata[7:0];
      end
   end

   // zero and negative flags; clear touches only zero
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         z_ff <= 1'b0;
         n_ff <= 1'b0;
      end else if ((phase == ccw_pkg::PH_Q4) && (op_ff == ccw_pkg::OP_CLR)) begin
         z_ff <= 1'b1;
      end else if ((phase == ccw_pkg::PH_Q4) && (op_ff == ccw_pkg::OP_INV)) begin
         z_ff <= (result_ff == 8'h00);
         n_ff <= result_ff[7];
      end else if (bus_we && !busy && (dp_addr_ff == `CCW_OFF_STATUS)) begin
         z_ff <= hwdata[`CCW_ST_Z];
         n_ff <= hwdata[`CCW_ST_N];
      end
   end

   // ************************************
   // watchdog
   // ************************************
   assign wdog_restart = (phase == ccw_pkg::PH_Q3) && (op_ff == ccw_pkg::OP_WDOG);

   ccw_watchdog #(
      .PERIOD (WDOG_PERIOD),
      .POST   (WDOG_POST)
   ) u_watchdog (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .enable  (ctrl_ff[`CCW_CTRL_WDEN]),
      .restart (wdog_restart),
      .count   (wdog_count),
      .post    (wdog_post),
      .timeout (wdog_pulse)
   );

   assign wdog_timeout = wdog_pulse;

   // timeout and power-down flags; the restart set wins over a timeout
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         to_ff   <= `CCW_RST_FLAG_HI;
         pwdn_ff <= `CCW_RST_FLAG_HI;
      end else if (wdog_restart) begin
         to_ff   <= 1'b1;
         pwdn_ff <= 1'b1;
      end else if (wdog_pulse) begin
         to_ff <= 1'b0;
      end
   end

   // ************************************
   // checks
   // ************************************
   a_clear_zero: assert property (@(posedge mclk) disable iff (!arst_n)
      ((phase == ccw_pkg::PH_Q4) && (op_ff == ccw_pkg::OP_CLR)) |->
         core_we && (result_ff == 8'h00) ##1 z_ff)
      else $error("clear did not write zero and set zero flag");

   a_clear_indexed: assert property (@(posedge mclk) disable iff (!arst_n)
      (start && (nxt_op == ccw_pkg::OP_CLR) && !hwdata[8] && ext_set_en &&
       (hwdata[7:0] <= 8'h5F)) |=>
         (ea_ff == $past(index_ff) + {4'h0, $past(hwdata[7:0])}))
      else $error("clear indexed address wrong");

   a_flags_restart: assert property (@(posedge mclk) disable iff (!arst_n)
      ((phase == ccw_pkg::PH_Q3) && (op_ff == ccw_pkg::OP_WDOG)) |=> to_ff && pwdn_ff)
      else $error("watchdog restart left a status flag low");

   a_invert_value: assert property (@(posedge mclk) disable iff (!arst_n)
      ((phase == ccw_pkg::PH_Q3) && (op_ff == ccw_pkg::OP_INV)) |=>
         (result_ff == ~$past(operand_ff)))
      else $error("complement result is not the inverse");

   a_invert_to_w: assert property (@(posedge mclk) disable iff (!arst_n)
      ((phase == ccw_pkg::PH_Q4) && (op_ff == ccw_pkg::OP_INV) && !dest_f_ff) |->
         !core_we ##1 (w_ff == $past(result_ff)))
      else $error("complement to working register failed");

   a_invert_to_f: assert property (@(posedge mclk) disable iff (!arst_n)
      ((phase == ccw_pkg::PH_Q4) && (op_ff == ccw_pkg::OP_INV) && dest_f_ff) |->
         core_we ##1 (mem[$past(ea_ff)] == $past(result_ff)))
      else $error("complement to file register failed");

   a_access_bank: assert property (@(posedge mclk) disable iff (!arst_n)
      (start && !hwdata[8] && !(ext_set_en && (hwdata[7:0] <= 8'h5F))) |=>
         (ea_ff == {($past(hwdata[7]) ? 4'hF : 4'h0), $past(hwdata[7:0])}))
      else $error("access bank address wrong");

   a_bank_select: assert property (@(posedge mclk) disable iff (!arst_n)
      (start && hwdata[8]) |=> (ea_ff == {$past(bank_ff), $past(hwdata[7:0])}))
      else $error("bank select address wrong");

   a_invert_indexed: assert property (@(posedge mclk) disable iff (!arst_n)
      (start && (nxt_op == ccw_pkg::OP_INV) && !hwdata[8] && ext_set_en &&
       (hwdata[7:0] <= 8'h5F)) |=>
         (ea_ff == $past(index_ff) + {4'h0, $past(hwdata[7:0])}))
      else $error("complement indexed address wrong");

   a_one_cycle: assert property (@(posedge mclk) disable iff (!arst_n)
      start |=> busy[*4] ##1 !busy)
      else $error("instruction did not take exactly four phases");

   a_invert_flags: assert property (@(posedge mclk) disable iff (!arst_n)
      ((phase == ccw_pkg::PH_Q4) && (op_ff == ccw_pkg::OP_INV)) |=>
         (z_ff == ($past(result_ff) == 8'h00)) && (n_ff == $past(result_ff[7])))
      else $error("complement flags wrong");
endmodule : ccw_core

// ---- test/clear_complement_wdt_ops_tb.sv ----
// self-checking bench for the clear/complement/watchdog instruction core
`timescale 1ns/1ps
`include "ccw_cfg.svh"
module clear_complement_wdt_ops_tb;
   // ****************
   // signals
   // ****************
   logic        mclk;        // core clock, 50 ns
   logic        arst_n;      // async reset, active low
   logic        hsel;        // bus select
   logic [31:0] haddr;       // bus address
   logic [1:0]  htrans;      // transfer kind
   logic        hwrite;      // write strobe
   logic [31:0] hwdata;      // write data
   logic [31:0] hrdata;      // read data
   logic        hreadyout;   // slave ready, also bus ready
   logic        hresp;       // slave response
   logic        ext_set_en;  // extended set enabled
   logic        wdog_timeout; // watchdog timeout pulse
   int          errors;      // mismatch count
   int          num_checks;  // comparison count
   logic [31:0] rd;          // last read word
   int unsigned ext, a, d, f, bnk, idx, w, st, v, op, adr, r, ew, es, em, n;

   // design with a short watchdog so the timeout comes within the run
   ccw_core #(.WDOG_PERIOD(8), .WDOG_POST(2)) u_ccw_core (
      .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ext_set_en(ext_set_en),
      .wdog_timeout(wdog_timeout)
   );

   // ****************
   // tasks
   // ****************
   // one single transfer: address phase held until ready, then data phase until ready
   task automatic bus(input logic wr_en, input logic [7:0] ad, input logic [31:0] wd);
      int k;
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, ad};
      hwrite <= wr_en;
      @(posedge mclk);
      k = 0;
      while (hreadyout !== 1'b1 && k < 20) begin
         @(posedge mclk);
         k++;
      end
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge mclk);
      while (hreadyout !== 1'b1 && k < 40) begin
         @(posedge mclk);
         k++;
      end
      // a slave that never answers counts as a mismatch
      if (hreadyout !== 1'b1) begin
         errors++;
         $display("ERROR t=%0t bus wait limit reached", $time);
      end
      rd = hrdata;
   endtask : bus

   // register write
   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      bus(1'b1, ad, wd);
   endtask : wr

   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // register read and compare
   task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
      bus(1'b0, ad, 32'h0);
      chk(rd, exp);
   endtask : rchk

   // poll the busy bit under a bound
   task automatic wait_idle();
      int k;
      k = 0;
      rd = 32'h100;
      while (rd[`CCW_ST_BUSY] !== 1'b0 && k < 10) begin
         bus(1'b0, `CCW_OFF_STATUS, 32'h0);
         k++;
      end
      chk({31'h0, rd[`CCW_ST_BUSY]}, 32'h0);
   endtask : wait_idle

   // print counts and verdict, then stop
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // ****************
   // clock and watchdog
   // ****************
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // cut a hang short well past the expected run length
   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      $display("ERROR t=%0t run did not finish", $time);
      report_and_stop();
   end

   // ****************
   // main sequence
   // ****************
   initial begin
      errors = 0;
      num_checks = 0;
      arst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      n = $urandom(90);
      repeat (5) @(posedge mclk);
      arst_n <= 1'b1;
      // reset values and an unmapped place
      rchk(`CCW_OFF_STATUS, 32'h0000000C);
      rchk(`CCW_OFF_CTRL, 32'h0);
      rchk(`CCW_OFF_WDOG, 32'h0);
      wr(8'h24, 32'hFFFFFFFF);
      rchk(8'h24, 32'h0);
      // random clear and complement operations at the addressing boundaries
      for (int i = 0; i < 40; i++) begin
         op = $urandom_range(1, 0);
         ext = $urandom_range(1, 0);
         a = $urandom_range(1, 0);
         d = $urandom_range(1, 0);
         case ($urandom_range(4, 0))
            0: f = 'h5F;
            1: f = 'h60;
            2: f = 'h7F;
            3: f = 'h80;
            default: f = $urandom_range(255, 0);
         endcase
         bnk = $urandom_range(15, 0);
         idx = $urandom_range(4095, 0);
         w = $urandom_range(255, 0);
         st = $urandom_range(3, 0);
         v = $urandom_range(255, 0);
         if (a) adr = bnk * 256 + f;
         else if (ext && f <= 95) adr = (idx + f) % 4096;
         else adr = (f < 128) ? f : 'hF00 + f;
         wr(`CCW_OFF_CTRL, ext);
         wr(`CCW_OFF_BANK, bnk);
         chk({31'h0, ext_set_en}, ext);
         wr(`CCW_OFF_INDEX, idx);
         wr(`CCW_OFF_WREG, w);
         wr(`CCW_OFF_STATUS, st);
         wr(`CCW_OFF_MADDR, adr);
         wr(`CCW_OFF_MDATA, v);
         wr(`CCW_OFF_INSTR, op ? ('h1C00 + d * 512 + a * 256 + f) : ('h6A00 + a * 256 + f));
         wait_idle();
         r = (~v) & 255;
         em = op ? (d ? r : v) : 0;
         ew = (op && !d) ? r : w;
         es = op ? ('hC + (r >> 7) * 2 + (r == 0)) : ('hC + (st & 2) + 1);
         rchk(`CCW_OFF_MDATA, em);
         rchk(`CCW_OFF_WREG, ew);
         rchk(`CCW_OFF_STATUS, es);
      end
      // unknown opcode runs its cycle with no effect; a working register write while busy is lost
      wr(`CCW_OFF_INSTR, 32'h0000FFFF);
      wr(`CCW_OFF_WREG, 32'h0000005A);
      wait_idle();
      rchk(`CCW_OFF_WREG, ew);
      rchk(`CCW_OFF_MDATA, em);
      rchk(`CCW_OFF_STATUS, es);
      rchk(`CCW_OFF_INSTR, 32'h0000FFFF);
      // watchdog runs out, then a restart with the counter frozen
      wr(`CCW_OFF_STATUS, 32'h0);
      wr(`CCW_OFF_CTRL, 32'h2);
      n = 0;
      while (wdog_timeout !== 1'b1 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      chk(n < 40, 32'h1);
      rchk(`CCW_OFF_STATUS, 32'h00000004);
      // let the postscaler step again so the restart has work to undo
      repeat (4) @(posedge mclk);
      wr(`CCW_OFF_CTRL, 32'h0);
      bus(1'b0, `CCW_OFF_WDOG, 32'h0);
      chk({31'h0, (rd[23:16] != 8'h00) && (rd[15:0] != 16'h0000)}, 32'h1);
      wr(`CCW_OFF_INSTR, 32'h00000004);
      wait_idle();
      rchk(`CCW_OFF_WDOG, 32'h0);
      rchk(`CCW_OFF_STATUS, 32'h0000000C);
      chk({31'h0, hresp}, 32'h0);
      report_and_stop();
   end
endmodule : clear_complement_wdt_ops_tb
